// file: design/nvm_ctrl_pkg.sv
package nvm_ctrl_pkg;
    // register word offsets as seen by the core
    localparam logic [15:0] ADDR_LOW_OFS = 16'h0762;
    localparam logic [15:0] ADDR_UPPER_OFS = 16'h0764;
    localparam logic [15:0] OP_CONTROL_OFS = 16'h0920;
    localparam logic [15:0] UNLOCK_KEY_OFS = 16'h9920;
    // control register fields
    localparam int START_BIT = 15;
    localparam int PERMIT_BIT = 14;
    localparam int ERROR_BIT = 13;
    localparam int TIMED_BIT = 8;
    localparam int OP_MSB = 6;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [15:0] CONTROL_WMASK = 16'h417f;
    // unlock key values
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;
    // operation select codes, low nibble of op_select_field
    localparam logic [3:0] OP_WORD_ERASE = 4'h4;
    localparam logic [3:0] OP_BLOCK_ERASE = 4'h5;
    localparam logic [3:0] OP_WORD_PROG = 4'h4;
    localparam logic [3:0] OP_BLOCK_PROG = 4'ha;
    localparam int ERASE_BIT = 6;
    // eeprom window in program space
    localparam logic [23:0] EE_BASE = 24'h7ff000;
    localparam logic [23:0] EE_LAST = 24'h7ffffe;
    localparam int EE_AW = 12;
    localparam int BLOCK_WORDS = 16;
    localparam logic [15:0] ERASED_WORD = 16'hffff;
    // nominal cycle time
    localparam int CYCLE_TIME_NS = 2000000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int CYCLE_CLKS = CYCLE_TIME_NS / CLK_PERIOD_NS;

    // unlock progress
    typedef enum logic [1:0] {
        LOCKED = 2'b00,
        GOT_FIRST = 2'b01,
        UNLOCKED = 2'b10
    } unlock_t;

    // register access from the core
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

    // table access from the core
    typedef struct packed {
        logic wr;
        logic rd;
        logic [23:0] ea;
        logic [15:0] wdata;
    } tbl_req_t;
endpackage : nvm_ctrl_pkg

// file: design/nvm_cell_array.sv
`timescale 1ns/100ps
`default_nettype none
// word storage standing in for the eeprom cells, registered read port
module nvm_cell_array #(
    parameter int AW = 12,
    parameter int DW = 16
) (
    input wire logic clk_i,
    input wire logic we_i, // write one word
    input wire logic [AW-1:0] waddr_i,
    input wire logic [DW-1:0] wdata_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [DW-1:0] rdata_o
);
    logic [DW-1:0] mem [2**AW]; // cell contents, no reset like real cells

    // write port
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    // read data always registered
    always_ff @(posedge clk_i) begin
        rdata_o <= mem[raddr_i];
    end
endmodule : nvm_cell_array
`default_nettype wire

// file: design/nvm_cycle_timer.sv
`timescale 1ns/100ps
`default_nettype none
// counts out one erase or program cycle and pulses at its end
module nvm_cycle_timer #(
    parameter int CLKS = 200000
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic start_i, // one-cycle launch
    output logic busy_o,
    output logic done_o // one-cycle pulse at the end
);
    logic [31:0] count; // cycles left

    // down-counter; a launch while busy is ignored
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            count <= 32'h0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i && !busy_o) begin
                count <= 32'(CLKS - 1);
                busy_o <= 1'b1;
            end else if (busy_o) begin
                if (count == 32'h0) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end else begin
                    count <= count - 32'h1;
                end
            end
        end
    end
endmodule : nvm_cycle_timer
`default_nettype wire

// file: design/nvm_unlock_write_erase_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module nvm_unlock_write_erase_ctrl
    import nvm_ctrl_pkg::*;
#(
    parameter int CYCLE_CLKS_P = CYCLE_CLKS // cycle length, shorten for simulation
) (
    input wire logic clk_i,
    input wire logic reset_i, // synchronous reset, any source
    input wire logic por_i, // high with reset_i when it is a power-up reset
    input wire reg_req_t reg_i, // register access
    input wire tbl_req_t tbl_i, // table access
    input wire logic done_flag_clear_i, // software clears the done flag
    output logic [15:0] reg_rdata_o,
    output logic [15:0] tbl_rdata_o,
    output logic done_flag_o // sticky completion flag
);
    logic [15:0] addr_low; // nvm_address_low
    logic [7:0] addr_upper; // nvm_address_upper payload
    logic start_bit; // control bit 15
    logic write_permit_bit; // control bit 14
    logic op_abort_error_bit; // control bit 13
    logic timed_write_select; // control bit 8
    logic [6:0] op_select_field; // control bits 6:0
    unlock_t unlock; // key sequence progress
    logic launch; // one-cycle start of the timer
    logic busy; // cycle in progress
    logic cyc_done; // end pulse from the timer
    logic [15:0] latch [BLOCK_WORDS]; // write latches
    logic [EE_AW-1:0] op_base; // target word captured at launch
    logic op_block; // captured block vs word
    logic op_erase; // captured erase vs program
    logic [4:0] op_idx; // word being committed at cycle end
    logic committing; // writing words into the array
    logic arr_we;
    logic [EE_AW-1:0] arr_waddr;
    logic [15:0] arr_wdata;
    logic [15:0] arr_rdata;
    logic [23:0] eff_addr;
    logic tbl_in_ee;
    logic ctrl_wr;
    logic key_wr;
    logic [15:0] ctrl_rd;

    assign eff_addr = {addr_upper, addr_low};
    assign tbl_in_ee = (tbl_i.ea >= EE_BASE) && (tbl_i.ea <= EE_LAST);
    assign ctrl_wr = reg_i.wr && (reg_i.addr == OP_CONTROL_OFS);
    assign key_wr = reg_i.wr && (reg_i.addr == UNLOCK_KEY_OFS);
    assign ctrl_rd = {start_bit, write_permit_bit, op_abort_error_bit, 4'h0,
                      timed_write_select, 1'b0, op_select_field};

    // launch needs unlock, permit from an earlier write, idle engine;
    // a launch while the last words still land would move the target
    // under the commit, so it is refused like a launch while busy
    assign launch = ctrl_wr && reg_i.wdata[START_BIT] && !start_bit &&
                    (unlock == UNLOCKED) && write_permit_bit && !busy &&
                    !committing;

    // unlock sequence: first key, second key, then the start write
    // the key is judged on its low byte only; the upper byte is ignored
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            unlock <= LOCKED;
        end else if (key_wr) begin
            case (unlock)
                LOCKED: unlock <= (reg_i.wdata[7:0] == KEY_FIRST) ? GOT_FIRST : LOCKED;
                GOT_FIRST: unlock <= (reg_i.wdata[7:0] == KEY_SECOND) ? UNLOCKED : LOCKED;
                UNLOCKED: unlock <= LOCKED;
                default: unlock <= LOCKED;
            endcase
        end else if (reg_i.wr) begin
            // any other write uses up or discards the key
            unlock <= LOCKED;
        end
    end

    // control register: start set-only, permit cleared only by software or power-up reset
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            start_bit <= 1'b0;
            timed_write_select <= 1'b0;
            op_select_field <= 7'h00;
            if (por_i) begin
                write_permit_bit <= CONTROL_RESET[PERMIT_BIT];
            end
        end else begin
            if (ctrl_wr) begin
                write_permit_bit <= reg_i.wdata[PERMIT_BIT];
                timed_write_select <= reg_i.wdata[TIMED_BIT];
                op_select_field <= reg_i.wdata[OP_MSB:0];
            end
            if (launch) begin
                start_bit <= 1'b1;
            end else if (cyc_done) begin
                start_bit <= 1'b0;
            end
        end
    end

    // error bit: a non power-up reset while busy marks the cycle as cut short;
    // software may also write it, to clear the mark after a rewrite
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            if (por_i) begin
                op_abort_error_bit <= 1'b0; // power-up starts clean
            end else if (busy) begin
                op_abort_error_bit <= 1'b1;
            end
        end else if (ctrl_wr) begin
            op_abort_error_bit <= reg_i.wdata[ERROR_BIT];
        end
    end

    // address registers track table instructions or direct writes;
    // only power-up clears them so a mid-cycle reset keeps them
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            if (por_i) begin
                addr_low <= 16'h0000;
                addr_upper <= 8'h00;
            end
        end else if (tbl_i.wr || tbl_i.rd) begin
            addr_low <= tbl_i.ea[15:0];
            addr_upper <= tbl_i.ea[23:16];
        end else if (reg_i.wr && reg_i.addr == ADDR_LOW_OFS) begin
            addr_low <= reg_i.wdata;
        end else if (reg_i.wr && reg_i.addr == ADDR_UPPER_OFS) begin
            addr_upper <= reg_i.wdata[7:0];
        end
    end

    // write latches loaded by table writes into the eeprom window
    always_ff @(posedge clk_i) begin
        if (tbl_i.wr && tbl_in_ee) begin
            latch[tbl_i.ea[4:1]] <= tbl_i.wdata;
        end
    end

    // capture the operation at launch so later control writes cannot alter it
    // this is also what lets software drop the permit bit mid-cycle
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            op_base <= '0;
            op_block <= 1'b0;
            op_erase <= 1'b0;
        end else if (launch) begin
            op_base <= eff_addr[EE_AW:1];
            op_block <= (op_select_field[3:0] == OP_BLOCK_ERASE) ||
                        (op_select_field[3:0] == OP_BLOCK_PROG);
            op_erase <= op_select_field[ERASE_BIT];
        end
    end

    // the timer runs on its own so the core is never held while a cycle lasts;
    // its length is fixed, not measured, so slow cells get no extra time
    nvm_cycle_timer #(
        .CLKS(CYCLE_CLKS_P)
    ) u_timer (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .start_i(launch),
        .busy_o(busy),
        .done_o(cyc_done)
    );

    // at the end of the cycle commit one or sixteen words to the cells
    // the cells change only after the timer ends, so a cut cycle leaves them
    // untouched and a rewrite after reset starts from the old contents
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            committing <= 1'b0;
            op_idx <= 5'h00;
        end else if (cyc_done) begin
            committing <= 1'b1;
            op_idx <= 5'h00;
        end else if (committing) begin
            if (!op_block || op_idx == 5'(BLOCK_WORDS - 1)) begin
                committing <= 1'b0;
            end
            op_idx <= op_idx + 5'h01;
        end
    end

    assign arr_we = committing;
    assign arr_waddr = op_block ? {op_base[EE_AW-1:4], op_idx[3:0]} : op_base;
    assign arr_wdata = op_erase ? ERASED_WORD :
                       latch[op_block ? op_idx[3:0] : op_base[3:0]];

    // reads follow the table address every cycle; no read strobe is needed
    nvm_cell_array #(
        .AW(EE_AW),
        .DW(16)
    ) u_cells (
        .clk_i(clk_i),
        .we_i(arr_we),
        .waddr_i(arr_waddr),
        .wdata_i(arr_wdata),
        .raddr_i(tbl_i.ea[EE_AW:1]),
        .rdata_o(arr_rdata)
    );

    // table read data; undefined while a cycle runs is allowed
    // two register stages: the cell read and this output flop
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            tbl_rdata_o <= 16'h0000;
        end else begin
            tbl_rdata_o <= arr_rdata;
        end
    end

    // register read mux, key reads as zero
    // a read of an unused offset returns zero rather than stale data
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_i.rd) begin
            case (reg_i.addr)
                OP_CONTROL_OFS: reg_rdata_o <= ctrl_rd;
                ADDR_LOW_OFS: reg_rdata_o <= addr_low;
                ADDR_UPPER_OFS: reg_rdata_o <= {8'h00, addr_upper};
                UNLOCK_KEY_OFS: reg_rdata_o <= 16'h0000;
                default: reg_rdata_o <= 16'h0000;
            endcase
        end
    end

    // done flag: set wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            done_flag_o <= 1'b0;
        end else if (cyc_done) begin
            done_flag_o <= 1'b1;
        end else if (done_flag_clear_i) begin
            done_flag_o <= 1'b0;
        end
    end

    a_launch_needs_key: assert property (@(posedge clk_i) disable iff (reset_i)
        $rose(busy) |-> $past(unlock) == UNLOCKED)
        else $error("cycle started without unlock");
    a_permit_earlier: assert property (@(posedge clk_i) disable iff (reset_i)
        $rose(busy) |-> $past(write_permit_bit))
        else $error("cycle started without earlier permit");
    a_start_set_only: assert property (@(posedge clk_i) disable iff (reset_i)
        $fell(start_bit) && !$past(reset_i) |-> $past(cyc_done))
        else $error("start bit fell without completion");
    a_done_sets_flag: assert property (@(posedge clk_i) disable iff (reset_i)
        cyc_done |=> done_flag_o && !start_bit)
        else $error("completion did not set flag");
    a_flag_holds: assert property (@(posedge clk_i) disable iff (reset_i)
        done_flag_o && !done_flag_clear_i |=> done_flag_o)
        else $error("done flag dropped without clear");
    a_permit_kept: assert property (@(posedge clk_i) disable iff (reset_i)
        write_permit_bit && !ctrl_wr |=> write_permit_bit)
        else $error("hardware cleared permit bit");
    a_busy_kept: assert property (@(posedge clk_i) disable iff (reset_i)
        busy && ctrl_wr && !reg_i.wdata[PERMIT_BIT] |=> busy || cyc_done)
        else $error("clearing permit disturbed cycle");
    a_key_discard: assert property (@(posedge clk_i) disable iff (reset_i)
        reg_i.wr && !key_wr |=> unlock == LOCKED)
        else $error("partial unlock kept after other write");
    a_key_reads_zero: assert property (@(posedge clk_i) disable iff (reset_i)
        reg_i.rd && reg_i.addr == UNLOCK_KEY_OFS |=> reg_rdata_o == 16'h0000)
        else $error("key register readable");
    a_addr_capture: assert property (@(posedge clk_i) disable iff (reset_i)
        tbl_i.wr |=> addr_low == $past(tbl_i.ea[15:0]) && addr_upper == $past(tbl_i.ea[23:16]))
        else $error("address not captured from table access");

    // further checks, one per rule of the device side
    // a plain reset in mid-cycle must leave a mark
    a_error_on_cut: assert property (@(posedge clk_i)
        reset_i && !por_i && busy |=> op_abort_error_bit)
        else $error("cut cycle left no error mark");
    // a plain reset keeps both address registers
    a_addr_kept: assert property (@(posedge clk_i)
        reset_i && !por_i |=> addr_low == $past(addr_low) &&
        addr_upper == $past(addr_upper))
        else $error("address lost across reset");
    // power-up leaves writes locked out
    a_permit_por_clear: assert property (@(posedge clk_i)
        reset_i && por_i |=> !write_permit_bit)
        else $error("permit bit survived power-up");
    // start without an earlier permit is ignored
    a_start_needs_permit: assert property (@(posedge clk_i) disable iff (reset_i)
        ctrl_wr && reg_i.wdata[START_BIT] && !write_permit_bit |=> !$rose(start_bit))
        else $error("start accepted without earlier permit");
    // start without the full key pair is ignored
    a_start_needs_key: assert property (@(posedge clk_i) disable iff (reset_i)
        ctrl_wr && reg_i.wdata[START_BIT] && unlock != UNLOCKED |=> !$rose(start_bit))
        else $error("start accepted without key pair");
    // the second key straight after the first unlocks
    a_key_pair: assert property (@(posedge clk_i) disable iff (reset_i)
        key_wr && unlock == GOT_FIRST && reg_i.wdata[7:0] == KEY_SECOND |=> unlock == UNLOCKED)
        else $error("key pair did not unlock");
    // a word operation commits exactly one word
    a_word_commit: assert property (@(posedge clk_i) disable iff (reset_i)
        cyc_done && !op_block |-> ##1 committing ##1 !committing)
        else $error("word commit length wrong");
    // a block operation commits exactly sixteen words
    a_block_commit: assert property (@(posedge clk_i) disable iff (reset_i)
        cyc_done && op_block |-> ##16 committing ##1 !committing)
        else $error("block commit length wrong");
    // a launch starts the background cycle at once
    a_runs_background: assert property (@(posedge clk_i) disable iff (reset_i)
        launch |=> busy)
        else $error("launch did not start the cycle");
    // a software clear drops the flag when no completion competes
    a_flag_clears: assert property (@(posedge clk_i) disable iff (reset_i)
        done_flag_o && done_flag_clear_i && !cyc_done |=> !done_flag_o)
        else $error("done flag ignored its clear");
    // an erase writes the erased pattern into every committed word
    a_erase_ones: assert property (@(posedge clk_i) disable iff (reset_i)
        arr_we && op_erase |-> arr_wdata == ERASED_WORD)
        else $error("erase wrote a wrong pattern");
endmodule : nvm_unlock_write_erase_ctrl
`default_nettype wire

// file: test/core_access_model.sv
`timescale 1ns/100ps
`default_nettype none
// behavioural processor core: issues one register or table access at a time
module core_access_model
    import nvm_ctrl_pkg::*;
(
    input wire logic clk_i,
    input wire logic [15:0] reg_rdata_i,
    input wire logic [15:0] tbl_rdata_i,
    output var reg_req_t reg_o,
    output var tbl_req_t tbl_o,
    output logic clear_o // software clear of the done flag
);
    // quiet bus at time zero
    initial begin
        reg_o = '0;
        tbl_o = '0;
        clear_o = 1'b0;
    end

    // strobe held over one taking edge; released bus shows inverted values so stale data never passes
    task automatic reg_access(input logic wr, input logic [15:0] a, input logic [15:0] d,
                              output logic [15:0] rdata);
        @(posedge clk_i);
        reg_o <= '{wr: wr, rd: !wr, addr: a, wdata: d};
        @(posedge clk_i);
        reg_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        @(posedge clk_i);
        #1 rdata = reg_rdata_i; // read data one cycle after the taking edge
    endtask : reg_access

    // table access; cells read at the taking edge, output flop loads one edge later,
    // so the data stands only until the following edge, when the released address lands
    task automatic tbl_access(input logic wr, input logic [23:0] ea, input logic [15:0] d,
                              output logic [15:0] rdata);
        @(posedge clk_i);
        tbl_o <= '{wr: wr, rd: !wr, ea: ea, wdata: d};
        @(posedge clk_i);
        tbl_o <= '{wr: 1'b0, rd: 1'b0, ea: ~ea, wdata: ~d};
        @(posedge clk_i);
        #1 rdata = tbl_rdata_i;
    endtask : tbl_access

    // one-cycle clear pulse
    task automatic clear_flag();
        @(posedge clk_i);
        clear_o <= 1'b1;
        @(posedge clk_i);
        clear_o <= 1'b0;
    endtask : clear_flag
endmodule : core_access_model
`default_nettype wire

// file: test/tb.sv
`timescale 1ns/100ps
`default_nettype none
// register-level checks of unlock, launch, completion and reset capture
module tb;
    import nvm_ctrl_pkg::*;
    localparam int CYC = 20; // shortened cycle keeps the run brief
    logic clk_i;
    logic reset_i;
    logic por_i;
    reg_req_t reg_req;
    tbl_req_t tbl_req;
    logic clear;
    logic [15:0] reg_rdata;
    logic [15:0] tbl_rdata;
    logic done_flag;
    logic [15:0] rd; // last value read back
    int fails = 0;
    int check_count = 0;
    int cycles = 0;

    nvm_unlock_write_erase_ctrl #(.CYCLE_CLKS_P(CYC)) dut_u (
        .clk_i(clk_i), .reset_i(reset_i), .por_i(por_i), .reg_i(reg_req), .tbl_i(tbl_req),
        .done_flag_clear_i(clear), .reg_rdata_o(reg_rdata), .tbl_rdata_o(tbl_rdata),
        .done_flag_o(done_flag));
    core_access_model core_u (
        .clk_i(clk_i), .reg_rdata_i(reg_rdata), .tbl_rdata_i(tbl_rdata),
        .reg_o(reg_req), .tbl_o(tbl_req), .clear_o(clear));

    // free-running 100 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // hang guard, well above the longest expected run
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        if (fails == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        core_u.reg_access(1'b1, a, d, rd);
    endtask : wr

    // masked register read compare
    task automatic rd_check(input logic [15:0] a, input logic [15:0] m, input logic [15:0] exp);
        core_u.reg_access(1'b0, a, 16'h0000, rd);
        check(rd & m, exp);
    endtask : rd_check

    task automatic tbl_check(input logic [23:0] ea, input logic [15:0] exp);
        core_u.tbl_access(1'b0, ea, 16'h0000, rd);
        check(rd, exp);
    endtask : tbl_check

    // permit first, then both keys back to back, then start; two idle cycles follow
    task automatic launch(input logic [15:0] ctrl);
        wr(OP_CONTROL_OFS, ctrl);
        wr(UNLOCK_KEY_OFS, {8'h00, KEY_FIRST});
        wr(UNLOCK_KEY_OFS, {8'h00, KEY_SECOND});
        wr(OP_CONTROL_OFS, ctrl | 16'h8000);
        repeat (2) @(posedge clk_i);
    endtask : launch

    // bounded wait for completion, flag must stick until cleared
    task automatic wait_done();
        int n;
        n = 0;
        while (done_flag !== 1'b1 && n < 4 * CYC) begin
            @(posedge clk_i);
            n++;
        end
        check({15'h0000, done_flag}, 16'h0001);
        repeat (3) @(posedge clk_i);
        #1 check({15'h0000, done_flag}, 16'h0001);
        core_u.clear_flag();
        @(posedge clk_i);
        #1 check({15'h0000, done_flag}, 16'h0000);
        rd_check(OP_CONTROL_OFS, 16'h8000, 16'h0000);
    endtask : wait_done

    initial begin
        reset_i = 1'b1;
        por_i = 1'b1;
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        por_i <= 1'b0;
        // power-up values, key never visible
        rd_check(OP_CONTROL_OFS, 16'hffff, CONTROL_RESET);
        rd_check(UNLOCK_KEY_OFS, 16'hffff, 16'h0000);
        // table access captures its effective address
        core_u.tbl_access(1'b1, EE_BASE + 24'h10, 16'h1234, rd);
        rd_check(ADDR_LOW_OFS, 16'hffff, 16'hf010);
        rd_check(ADDR_UPPER_OFS, 16'h00ff, 16'h007f);
        // permit and start in one write must not launch
        wr(UNLOCK_KEY_OFS, 16'h0055);
        wr(UNLOCK_KEY_OFS, 16'h00aa);
        wr(OP_CONTROL_OFS, 16'hc044);
        rd_check(OP_CONTROL_OFS, 16'hc000, 16'h4000);
        // keys reversed: refused
        wr(UNLOCK_KEY_OFS, 16'h00aa);
        wr(UNLOCK_KEY_OFS, 16'h0055);
        wr(OP_CONTROL_OFS, 16'hc044);
        rd_check(OP_CONTROL_OFS, 16'h8000, 16'h0000);
        // another write between the keys discards the partial unlock
        wr(UNLOCK_KEY_OFS, 16'h0055);
        wr(ADDR_LOW_OFS, 16'hf010);
        wr(UNLOCK_KEY_OFS, 16'h00aa);
        wr(OP_CONTROL_OFS, 16'hc044);
        rd_check(OP_CONTROL_OFS, 16'h8000, 16'h0000);
        check({15'h0000, done_flag}, 16'h0000);
        // word erase, permit cleared by software mid-cycle while start stays set
        launch(16'h4044);
        wr(OP_CONTROL_OFS, 16'h0044);
        rd_check(OP_CONTROL_OFS, 16'hc000, 16'h8000);
        wait_done();
        tbl_check(EE_BASE + 24'h10, ERASED_WORD);
        // load latch then one-word program
        core_u.tbl_access(1'b1, EE_BASE + 24'h10, 16'h5a3c, rd);
        launch(16'h4004);
        wait_done();
        rd_check(OP_CONTROL_OFS, 16'h4000, 16'h4000);
        tbl_check(EE_BASE + 24'h10, 16'h5a3c);
        // block erase at an aligned block set up through the address registers
        wr(ADDR_UPPER_OFS, 16'h007f);
        wr(ADDR_LOW_OFS, 16'hf020);
        launch(16'h4045);
        wait_done();
        for (int i = 0; i < BLOCK_WORDS; i++) begin
            tbl_check(EE_BASE + 24'h20 + 24'(2 * i), ERASED_WORD);
        end
        // sixteen latches then one block program
        for (int i = 0; i < BLOCK_WORDS; i++) begin
            core_u.tbl_access(1'b1, EE_BASE + 24'h20 + 24'(2 * i), 16'h0100 + 16'(i), rd);
        end
        launch(16'h400a);
        wait_done();
        for (int i = 0; i < BLOCK_WORDS; i++) begin
            tbl_check(EE_BASE + 24'h20 + 24'(2 * i), 16'h0100 + 16'(i));
        end
        tbl_check(EE_BASE + 24'h10, 16'h5a3c);
        // non power-up reset in mid-cycle flags the error, keeps permit and address
        wr(ADDR_LOW_OFS, 16'hf010);
        launch(16'h4044);
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b1;
        @(posedge clk_i);
        reset_i <= 1'b0;
        rd_check(OP_CONTROL_OFS, 16'he000, 16'h6000);
        rd_check(ADDR_LOW_OFS, 16'hffff, 16'hf010);
        give_verdict();
    end
endmodule : tb
`default_nettype wire
